// *** src/tpoc_ctrl.sv ***
// Timing pattern output unit: APB registers, trigger select and pin update
// Functional notes
// - Group 2 trigger field picks timer channel 0..3 compare match.
// - Group 3 trigger field picks timer channel 0..3 compare match.
// - Upper next-data bits reach port B only where enabled; enables reset 0.
// - Lower next-data bits reach port A only where enabled; enables reset 0.
// - Groups 2,3 shared trigger: full byte at first address, alternate reads ones.
// - Groups 2,3 split: group 3 upper first byte, group 2 lower alternate.
// - Groups 0,1 shared trigger: full byte at first address, alternate reads ones.
// - Groups 0,1 split: group 1 in upper nibble of first byte, lower ones.
// - Groups 0,1 split: group 0 in lower nibble of alternate byte.
// - Enabled outputs update at compare match A of selected channel.
//
// The APB interface to the registers is this design's own decision.
`include "tpoc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tpoc_ctrl
    import tpoc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  cmp_match_a,
    output logic      [7:0]  port_a_pin,
    output logic      [7:0]  port_b_pin
);
    tpoc_byte_t  trig_sel_reg, trig_sel_next;
    tpoc_byte_t  en_hi_reg, en_hi_next;
    tpoc_byte_t  en_lo_reg, en_lo_next;
    logic [15:0] np_reg, np_next;
    tpoc_byte_t  pin_a_reg, pin_a_next;
    tpoc_byte_t  pin_b_reg, pin_b_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;

    tpoc_sel_t   sel0, sel1, sel2, sel3;
    logic [3:0]  grp_hit;
    logic        same01, same23;
    tpoc_idx_t   idx;
    logic        hit_map;
    logic        wr_do;
    tpoc_byte_t  wb;
    tpoc_byte_t  rd_byte;

    assign sel0 = trig_sel_reg[`TPOC_GRP0_SEL_LSB +: 2];
    assign sel1 = trig_sel_reg[`TPOC_GRP1_SEL_LSB +: 2];
    assign sel2 = trig_sel_reg[`TPOC_GRP2_SEL_LSB +: 2];
    assign sel3 = trig_sel_reg[`TPOC_GRP3_SEL_LSB +: 2];
    assign same01 = (sel0 == sel1);
    assign same23 = (sel2 == sel3);
    assign idx = paddr[17:2];
    assign wb = pwdata[7:0];
    assign wr_do = psel && penable && pready_reg && pwrite && !pslverr_reg;

    always_comb begin
        grp_hit[0] = cmp_match_a[sel0];
        grp_hit[1] = cmp_match_a[sel1];
        grp_hit[2] = cmp_match_a[sel2];
        grp_hit[3] = cmp_match_a[sel3];
    end

    // Address decode and read mux
    always_comb begin
        hit_map = (paddr[1:0] == 2'b00);
        rd_byte = 8'h00;
        case (idx)
            `TPOC_IDX_TRIG_SEL:  rd_byte = trig_sel_reg;
            `TPOC_IDX_EN_HIGH:   rd_byte = en_hi_reg;
            `TPOC_IDX_EN_LOW:    rd_byte = en_lo_reg;
            `TPOC_IDX_NP_HI_PRI: begin
                if (same23) begin
                    rd_byte = np_reg[15:8];
                end else begin
                    rd_byte = {np_reg[15:12], `TPOC_UNUSED_NIB};
                end
            end
            `TPOC_IDX_NP_HI_ALT: begin
                if (same23) begin
                    rd_byte = `TPOC_UNUSED_BYTE;
                end else begin
                    rd_byte = {`TPOC_UNUSED_NIB, np_reg[11:8]};
                end
            end
            `TPOC_IDX_NP_LO_PRI: begin
                if (same01) begin
                    rd_byte = np_reg[7:0];
                end else begin
                    rd_byte = {np_reg[7:4], `TPOC_UNUSED_NIB};
                end
            end
            `TPOC_IDX_NP_LO_ALT: begin
                if (same01) begin
                    rd_byte = `TPOC_UNUSED_BYTE;
                end else begin
                    rd_byte = {`TPOC_UNUSED_NIB, np_reg[3:0]};
                end
            end
            `TPOC_IDX_PIN_STAT:  rd_byte = pin_a_reg;
            default:             hit_map = 1'b0;
        endcase
    end

    // Bus phase: answer is prepared in the setup cycle, pready in the access cycle
    always_comb begin
        pready_next = psel && !penable;
        pslverr_next = psel && !penable && !hit_map;
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            prdata_next = (hit_map && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Register writes; unused nibbles of the packed bytes ignore written data
    always_comb begin
        trig_sel_next = trig_sel_reg;
        en_hi_next = en_hi_reg;
        en_lo_next = en_lo_reg;
        np_next = np_reg;
        if (wr_do) begin
            case (idx)
                `TPOC_IDX_TRIG_SEL:  trig_sel_next = wb;
                `TPOC_IDX_EN_HIGH:   en_hi_next = wb;
                `TPOC_IDX_EN_LOW:    en_lo_next = wb;
                `TPOC_IDX_NP_HI_PRI: begin
                    if (same23) begin
                        np_next[15:8] = wb;
                    end else begin
                        np_next[15:12] = wb[7:4];
                    end
                end
                `TPOC_IDX_NP_HI_ALT: begin
                    if (!same23) begin
                        np_next[11:8] = wb[3:0];
                    end
                end
                `TPOC_IDX_NP_LO_PRI: begin
                    if (same01) begin
                        np_next[7:0] = wb;
                    end else begin
                        np_next[7:4] = wb[7:4];
                    end
                end
                `TPOC_IDX_NP_LO_ALT: begin
                    if (!same01) begin
                        np_next[3:0] = wb[3:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Pin update at the selected compare match, per bit under its enable
    always_comb begin
        pin_a_next = pin_a_reg;
        pin_b_next = pin_b_reg;
        for (int i = 0; i < 4; i++) begin
            if (grp_hit[0] && en_lo_reg[i]) begin
                pin_a_next[i] = np_reg[i];
            end
            if (grp_hit[1] && en_lo_reg[i+4]) begin
                pin_a_next[i+4] = np_reg[i+4];
            end
            if (grp_hit[2] && en_hi_reg[i]) begin
                pin_b_next[i] = np_reg[i+8];
            end
            if (grp_hit[3] && en_hi_reg[i+4]) begin
                pin_b_next[i+4] = np_reg[i+12];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_sel_reg <= `TPOC_RST_TRIG_SEL;
            en_hi_reg <= `TPOC_RST_EN;
            en_lo_reg <= `TPOC_RST_EN;
            np_reg <= `TPOC_RST_NP;
            pin_a_reg <= `TPOC_RST_PINS;
            pin_b_reg <= `TPOC_RST_PINS;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            trig_sel_reg <= trig_sel_next;
            en_hi_reg <= en_hi_next;
            en_lo_reg <= en_lo_next;
            np_reg <= np_next;
            pin_a_reg <= pin_a_next;
            pin_b_reg <= pin_b_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign port_a_pin = pin_a_reg;
    assign port_b_pin = pin_b_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_setup;
    assign rd_setup = psel && !penable && !pwrite;

    sequence s_wr_lo_pri;
        psel && !penable && pwrite && paddr == {`TPOC_IDX_NP_LO_PRI, 2'b00} && same01
        ##1 psel && penable && pready;
    endsequence

    property p_grp2_copy;
        cmp_match_a[sel2] && en_hi_reg[0] |=> pin_b_reg[0] == $past(np_reg[8]);
    endproperty
    a_grp2_copy: assert property (p_grp2_copy)
        else $error("Group 2 bit not copied on selected match");

    property p_grp3_copy;
        cmp_match_a[sel3] && en_hi_reg[7] |=> pin_b_reg[7] == $past(np_reg[15]);
    endproperty
    a_grp3_copy: assert property (p_grp3_copy)
        else $error("Group 3 bit not copied on selected match");

    property p_hi_disabled;
        !en_hi_reg[1] |=> pin_b_reg[1] == $past(pin_b_reg[1]);
    endproperty
    a_hi_disabled: assert property (p_hi_disabled)
        else $error("Disabled port B bit changed");

    property p_lo_disabled;
        !en_lo_reg[2] |=> pin_a_reg[2] == $past(pin_a_reg[2]);
    endproperty
    a_lo_disabled: assert property (p_lo_disabled)
        else $error("Disabled port A bit changed");

    property p_no_match_hold;
        !cmp_match_a[sel0] |=> $stable(pin_a_reg[3:0]);
    endproperty
    a_no_match_hold: assert property (p_no_match_hold)
        else $error("Group 0 changed without its match");

    property p_same23_alt;
        rd_setup && same23 && paddr == {`TPOC_IDX_NP_HI_ALT, 2'b00}
        |=> pready && prdata[7:0] == `TPOC_UNUSED_BYTE;
    endproperty
    a_same23_alt: assert property (p_same23_alt)
        else $error("Unused alternate high byte not all ones");

    property p_diff23_pri;
        rd_setup && !same23 && paddr == {`TPOC_IDX_NP_HI_PRI, 2'b00}
        |=> prdata[7:0] == {$past(np_reg[15:12]), `TPOC_UNUSED_NIB};
    endproperty
    a_diff23_pri: assert property (p_diff23_pri)
        else $error("Split high primary byte wrong");

    property p_same01_write;
        s_wr_lo_pri |=> np_reg[7:0] == $past(pwdata[7:0]);
    endproperty
    a_same01_write: assert property (p_same01_write)
        else $error("Shared low byte write lost");

    property p_diff01_pri;
        rd_setup && !same01 && paddr == {`TPOC_IDX_NP_LO_PRI, 2'b00}
        |=> prdata[3:0] == `TPOC_UNUSED_NIB && prdata[7:4] == $past(np_reg[7:4]);
    endproperty
    a_diff01_pri: assert property (p_diff01_pri)
        else $error("Split low primary byte wrong");

    property p_diff01_alt;
        rd_setup && !same01 && paddr == {`TPOC_IDX_NP_LO_ALT, 2'b00}
        |=> prdata[7:4] == `TPOC_UNUSED_NIB && prdata[3:0] == $past(np_reg[3:0]);
    endproperty
    a_diff01_alt: assert property (p_diff01_alt)
        else $error("Split low alternate byte wrong");

    property p_same_copy_cycle;
        cmp_match_a[sel1] && en_lo_reg[4] && en_lo_reg[5]
        |=> pin_a_reg[5:4] == $past(np_reg[5:4]);
    endproperty
    a_same_copy_cycle: assert property (p_same_copy_cycle)
        else $error("Copy not in the match cycle");

    property p_share_eq;
        rd_setup && sel0 != sel1 && paddr == {`TPOC_IDX_NP_LO_ALT, 2'b00}
        |=> prdata[7:0] != `TPOC_UNUSED_BYTE || $past(np_reg[3:0]) == 4'hf;
    endproperty
    a_share_eq: assert property (p_share_eq)
        else $error("Packing ignores differing select fields");
endmodule : tpoc_ctrl
`default_nettype wire

// *** include/tpoc_defines.svh ***
// Register indices, field positions and reset values of the pattern output unit
`ifndef TPOC_DEFINES_SVH
`define TPOC_DEFINES_SVH
`define TPOC_IDX_TRIG_SEL   16'h00a1
`define TPOC_IDX_EN_HIGH    16'h00a2
`define TPOC_IDX_EN_LOW     16'h00a3
`define TPOC_IDX_NP_HI_PRI  16'hffa4
`define TPOC_IDX_NP_LO_PRI  16'hffa5
`define TPOC_IDX_NP_HI_ALT  16'hffa6
`define TPOC_IDX_NP_LO_ALT  16'hffa7
`define TPOC_IDX_PIN_STAT   16'h00b0
`define TPOC_RST_TRIG_SEL   8'hff
`define TPOC_RST_EN         8'h00
`define TPOC_RST_NP         16'h0000
`define TPOC_RST_PINS       8'h00
`define TPOC_GRP0_SEL_LSB   0
`define TPOC_GRP1_SEL_LSB   2
`define TPOC_GRP2_SEL_LSB   4
`define TPOC_GRP3_SEL_LSB   6
`define TPOC_UNUSED_NIB     4'hf
`define TPOC_UNUSED_BYTE    8'hff
`endif

// *** include/tpoc_pkg.sv ***
// Types shared by the pattern output unit
package tpoc_pkg;
    typedef logic [15:0] tpoc_idx_t;
    typedef logic [1:0]  tpoc_sel_t;
    typedef logic [7:0]  tpoc_byte_t;
endpackage : tpoc_pkg

// *** verification/tpoc_timer_model.sv ***
// Timer model that raises compare match A pulses on the requested channels
`timescale 1ns/10ps
`default_nettype none
module tpoc_timer_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] fire,
    output logic      [3:0] cmp_match_a
);
    logic [3:0] match_next;
    // A compare match follows fire one clock later and lasts as long as fire is held
    always_comb begin
        match_next = fire;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_match_a <= 4'h0;
        end else begin
            cmp_match_a <= match_next;
        end
    end
endmodule : tpoc_timer_model
`default_nettype wire

// *** verification/timing_pattern_output_ctrl_test.sv ***
// Self-checking test of the pattern output unit over its register bus
`include "tpoc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module timing_pattern_output_ctrl_test;
    import tpoc_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  fire;
    logic [3:0]  cmp_match_a;
    logic [7:0]  port_a_pin;
    logic [7:0]  port_b_pin;
    tpoc_byte_t  exp_a;
    tpoc_byte_t  exp_b;
    tpoc_byte_t  d;
    int          err_total;
    int          compares;
    tpoc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_match_a(cmp_match_a), .port_a_pin(port_a_pin),
        .port_b_pin(port_b_pin));
    tpoc_timer_model i_timer (.pclk(pclk), .presetn(presetn), .fire(fire),
        .cmp_match_a(cmp_match_a));
    always #50 pclk = ~pclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task automatic xfer(input logic w, input tpoc_idx_t idx, input tpoc_byte_t wd,
                        input tpoc_byte_t exp, input logic exp_err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 32'h00000001);
        chk({31'h0, pslverr}, {31'h0, exp_err});
        if (!w) begin
            chk(prdata, {24'h000000, exp});
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input tpoc_idx_t idx, input tpoc_byte_t wd);
        xfer(1'b1, idx, wd, 8'h00, 1'b0);
    endtask : wr
    task automatic rd(input tpoc_idx_t idx, input tpoc_byte_t exp);
        xfer(1'b0, idx, 8'h00, exp, 1'b0);
    endtask : rd
    // Request match pulses, then look at the pins once the copy has landed
    task automatic pulse(input logic [3:0] m, input tpoc_byte_t ea, input tpoc_byte_t eb);
        @(posedge pclk);
        fire <= m;
        @(posedge pclk);
        fire <= 4'h0;
        repeat (2) @(posedge pclk);
        chk({16'h0000, port_b_pin, port_a_pin}, {16'h0000, eb, ea});
    endtask : pulse
    initial begin
        pclk      = 1'b0;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 18'h00000;
        pwdata    = 32'h00000000;
        fire      = 4'h0;
        err_total = 0;
        compares  = 0;
        exp_a     = 8'h00;
        exp_b     = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TPOC_IDX_TRIG_SEL, 8'hff);
        rd(`TPOC_IDX_EN_HIGH, 8'h00);
        rd(`TPOC_IDX_EN_LOW, 8'h00);
        rd(`TPOC_IDX_NP_HI_PRI, 8'h00);
        rd(`TPOC_IDX_NP_HI_ALT, 8'hff);
        rd(`TPOC_IDX_NP_LO_PRI, 8'h00);
        rd(`TPOC_IDX_NP_LO_ALT, 8'hff);
        xfer(1'b0, 16'h0010, 8'h00, 8'h00, 1'b1);
        wr(`TPOC_IDX_NP_HI_PRI, 8'hff);
        wr(`TPOC_IDX_NP_LO_PRI, 8'hff);
        pulse(4'hf, 8'h00, 8'h00);
        wr(`TPOC_IDX_EN_HIGH, 8'h0f);
        wr(`TPOC_IDX_EN_LOW, 8'hf0);
        rd(`TPOC_IDX_EN_HIGH, 8'h0f);
        rd(`TPOC_IDX_EN_LOW, 8'hf0);
        for (int ch = 0; ch < 4; ch++) begin
            d = tpoc_byte_t'(ch * 8'h11 + 8'h96);
            wr(`TPOC_IDX_TRIG_SEL, {4{2'(ch)}});
            wr(`TPOC_IDX_NP_HI_PRI, d);
            wr(`TPOC_IDX_NP_LO_PRI, ~d);
            rd(`TPOC_IDX_NP_HI_PRI, d);
            rd(`TPOC_IDX_NP_LO_ALT, 8'hff);
            pulse(4'hf ^ (4'h1 << ch), exp_a, exp_b);
            exp_b = (exp_b & 8'hf0) | (d & 8'h0f);
            exp_a = (exp_a & 8'h0f) | (~d & 8'hf0);
            pulse(4'h1 << ch, exp_a, exp_b);
        end
        // Every group on its own channel: 3 on 0, 2 on 1, 1 on 2, 0 on 3
        wr(`TPOC_IDX_TRIG_SEL, 8'h1b);
        wr(`TPOC_IDX_EN_HIGH, 8'hff);
        wr(`TPOC_IDX_EN_LOW, 8'hff);
        wr(`TPOC_IDX_NP_HI_PRI, 8'h9a);
        wr(`TPOC_IDX_NP_HI_ALT, 8'h37);
        wr(`TPOC_IDX_NP_LO_PRI, 8'hc4);
        wr(`TPOC_IDX_NP_LO_ALT, 8'h5e);
        rd(`TPOC_IDX_NP_HI_PRI, 8'h9f);
        rd(`TPOC_IDX_NP_HI_ALT, 8'hf7);
        rd(`TPOC_IDX_NP_LO_PRI, 8'hcf);
        rd(`TPOC_IDX_NP_LO_ALT, 8'hfe);
        exp_b = {4'h9, exp_b[3:0]};
        pulse(4'h1, exp_a, exp_b);
        exp_b = {exp_b[7:4], 4'h7};
        pulse(4'h2, exp_a, exp_b);
        exp_a = {4'hc, exp_a[3:0]};
        pulse(4'h4, exp_a, exp_b);
        exp_a = {exp_a[7:4], 4'he};
        pulse(4'h8, exp_a, exp_b);
        rd(`TPOC_IDX_PIN_STAT, exp_a);
        wr(`TPOC_IDX_TRIG_SEL, 8'h00);
        rd(`TPOC_IDX_NP_HI_PRI, 8'h97);
        rd(`TPOC_IDX_NP_HI_ALT, 8'hff);
        rd(`TPOC_IDX_NP_LO_PRI, 8'hce);
        results();
    end
    // Cuts a hang short well after the tests should have ended
    initial begin
        #400000;
        err_total++;
        results();
    end
endmodule : timing_pattern_output_ctrl_test
`default_nettype wire
